/* File: inc/rbs_pkg.sv */
// Constants, field layouts and enumerations of the receive timing block.
// Assumes a single clock domain and synchronous active-high reset.
package rbs_pkg;
  localparam logic [3:0] ADDR_RX_TIMING   = 4'h0;
  localparam logic [3:0] ADDR_LOOP_FILTER = 4'h1;
  localparam logic [3:0] ADDR_JITTER      = 4'h2;
  localparam logic [3:0] ADDR_MODEM_TMG   = 4'h3;
  localparam logic [3:0] ADDR_MODEM_DLY   = 4'h4;
  localparam logic [3:0] ADDR_ROLE        = 4'h5;
  localparam logic [3:0] ADDR_RX_MUX      = 4'h6;
  localparam logic [3:0] ADDR_IRQ_CAUSE   = 4'h7;
  localparam logic [3:0] ADDR_IRQ_MASK    = 4'h8;
  localparam logic [3:0] ADDR_RESYNC      = 4'h9;
  // rx_timing_ctrl fields
  localparam int RT_ENABLE = 0;
  localparam int RT_SLOW   = 1;
  localparam int RT_FREEZE = 3;
  localparam int RT_TRACK  = 6;
  localparam int RT_SYNCED = 7;
  // loop_filter_fade_control fields
  localparam int LF_ACQ_LSB = 0;
  localparam int LF_TRK_LSB = 2;
  localparam int LF_INDEP   = 4;
  localparam int LF_FADE    = 5;
  localparam int LF_LONG_TERM_CORRECT_ENABLE   = 7;
  localparam int MT_OVERRIDE = 1;
  localparam int MC_MARKER   = 0;
  localparam int MC_SYNC_ERR = 3;
  localparam int MX_TOL      = 3;
  localparam logic [7:0] RST_ZERO   = 8'h00;
  localparam logic [7:0] RST_JITTER = 8'h24;
  localparam logic [7:0] RST_MASK   = 8'h09;
  localparam logic [1:0] MUX_SINGLE  = 2'h0;
  localparam logic [1:0] MUX_TWO_WAY = 2'h1;
  localparam logic [1:0] MUX_REVERSE = 2'h2;
  localparam logic [1:0] MUX_CLEAR   = 2'h3;
  localparam int PRE_TWO_WAY = 10;
  localparam int PRE_REVERSE = 12;
  localparam int MARK_BITS   = 24;
  localparam int LT_FRAMES   = 32;
  localparam int LT_SHIFT    = 5;
  localparam int MIN_VALID   = 8;
  localparam int TRK_SHIFT   = 2;
  localparam int CW_BITS     = 64;
  localparam int CW_DATA     = 48;
  localparam int CW_CHECK    = 15;
  localparam int SYNC_BITS   = 16;
  localparam int MAX_WORDS   = 6;
  localparam logic [15:0] PKT_SYNC = 16'hC4D7;
  typedef enum logic [1:0] {SY_SEARCH = 2'b00, SY_LOCK = 2'b01} rbs_sync_t;
  typedef enum logic [1:0] {LT_IDLE = 2'b00, LT_MEAS = 2'b01, LT_APPLY = 2'b11} rbs_lt_t;
  typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_SYNC = 2'b01, TX_WORD = 2'b11} rbs_tx_t;
endpackage

/* File: design/rbs_timing.sv */
// Receive timing recovery, fade detection, marker lock and code word send.
// Assumes rx data synchronous to ref_clk_in and a register master per port.
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module rbs_timing
  import rbs_pkg::*;
#(
  parameter int          BIT_CYC    = 36,
  parameter int          FRAME_BITS = 160,
  parameter logic [23:0] MARKER     = 24'h5A_3C96,
  parameter logic [23:0] PMARKER    = 24'hA6_59C3
) (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  input  wire logic [3:0]  addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [7:0]  rdata_out,
  input  wire logic        rx_data_in,
  input  wire logic        receiver_on_in,
  input  wire logic [47:0] cw_data_in,
  input  wire logic [14:0] cw_check_in,
  input  wire logic        cw_first_in,
  input  wire logic        cw_valid_in,
  output logic             cw_ready_out,
  output logic             tx_bit_out,
  output logic             tx_allowed_out,
  output logic             synced_out,
  output logic             fade_out,
  output logic             jitter_irq_out,
  output logic             marker_irq_out,
  output logic             slip_out,
  output logic             frame_start_out,
  output logic      [7:0]  modem_delay_out
);
  localparam int PW = $clog2(BIT_CYC) + 2;
  localparam int FW = $clog2(FRAME_BITS);
  localparam logic signed [PW-1:0] PMAX = PW'(BIT_CYC - 1);
  localparam logic signed [PW-1:0] HALF = PW'(BIT_CYC / 2);
  localparam logic [FW-1:0] FLAST = FW'(FRAME_BITS - 1);

  logic [7:0] rt_reg, lf_reg, jit_reg, mt_reg, dly_reg, role_reg, mux_reg;
  logic [7:0] cause_reg, mask_reg;
  logic       fade_reg;
  rbs_sync_t  sync_reg;
  rbs_lt_t    lt_reg;
  rbs_tx_t    tx_reg;

  // Role and mode decode
  logic portable, fixed_u, indep, clr_mode, tol, recov, freeze, locked;
  assign portable = role_reg[0];
  assign fixed_u  = ~portable;
  assign indep    = fixed_u & lf_reg[LF_INDEP];
  assign clr_mode = mux_reg[1:0] == MUX_CLEAR;
  assign tol      = mux_reg[MX_TOL];
  assign recov    = rt_reg[RT_ENABLE];
  assign freeze   = recov & rt_reg[RT_FREEZE];
  assign locked   = sync_reg == SY_LOCK;

  logic wr_resync;
  assign wr_resync = wr_in & (addr_in == ADDR_RESYNC);

  // Bit phase and edge detection
  logic signed [PW-1:0] phase_reg, phase_next, err, corr, lt_off_reg;
  logic prev_rx_reg, edge_s, bit_en;
  logic [1:0] shift;
  logic [FW-1:0] bit_cnt_reg;
  logic odd_reg, frame_end;
  assign edge_s    = rx_data_in ^ prev_rx_reg;
  assign bit_en    = phase_reg == PMAX;
  assign frame_end = bit_en & (bit_cnt_reg == FLAST);
  assign err       = (phase_reg < HALF) ? phase_reg : phase_reg - PW'(BIT_CYC);

  logic tracking;
  assign tracking = locked | rt_reg[RT_SLOW];
  // Tracking clips errors beyond the jitter limit so they count no more than the limit
  logic signed [PW-1:0] err_w, lim;
  assign lim = PW'(jit_reg[7:4]);
  always_comb begin
    err_w = err;
    shift = lf_reg[LF_ACQ_LSB +: 2];
    if (tracking) begin
      shift = lf_reg[LF_TRK_LSB +: 2];
      if (err > lim) err_w = lim;
      else if (err < -lim) err_w = -lim;
    end
  end

  logic adj_ok;
  assign adj_ok = recov & ~freeze & ~fade_reg & edge_s & receiver_on_in;
  assign corr   = adj_ok ? (err_w >>> (32'(shift) + TRK_SHIFT * 32'(tracking))) : PW'(0);

  logic lt_add;
  assign lt_add = portable & (lt_reg == LT_APPLY) & frame_end;

  logic slip_c;
  always_comb begin
    phase_next = (bit_en ? PW'(0) : phase_reg + PW'(1)) - corr;
    if (lt_add) phase_next = phase_next + lt_off_reg;
    slip_c = 1'b0;
    if (phase_next > PMAX) begin
      phase_next = phase_next - PW'(BIT_CYC);
      slip_c = fixed_u;
    end else if (phase_next < 0) begin
      phase_next = phase_next + PW'(BIT_CYC);
      slip_c = fixed_u;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      phase_reg   <= '0;
      prev_rx_reg <= 1'b0;
      slip_out    <= 1'b0;
    end else begin
      prev_rx_reg <= rx_data_in;
      phase_reg   <= phase_next;
      slip_out    <= slip_c;
    end
  end

  // Marker search
  logic [23:0] mk_sh_reg, pat, diff;
  logic [4:0] nerr;
  logic match, mark_pos;
  logic [FW-1:0] mark_end;
  always_comb begin
    pat = (mux_reg[1:0] == MUX_REVERSE) ? PMARKER : MARKER;
    if (portable) pat = ~pat;
    diff = mk_sh_reg ^ pat;
    nerr = '0;
    for (int i = 0; i < MARK_BITS; i++) nerr = nerr + 5'(diff[i]);
  end
  assign match = tol ? (nerr <= 5'h01) : (nerr == 5'h00);
  assign mark_end = (mux_reg[1:0] == MUX_REVERSE) ? FW'(PRE_REVERSE + MARK_BITS)
                                                 : FW'(PRE_TWO_WAY + MARK_BITS);
  assign mark_pos = bit_cnt_reg == mark_end - FW'(1);

  logic syn_mux, det, miss, reref;
  assign syn_mux = (mux_reg[1:0] == MUX_TWO_WAY) | (mux_reg[1:0] == MUX_REVERSE);
  assign det  = bit_en & syn_mux & match & receiver_on_in;
  assign miss = bit_en & locked & syn_mux & mark_pos & ~match;
  assign reref = det & ((sync_reg == SY_SEARCH) |
                 (indep & (mux_reg[1:0] == MUX_TWO_WAY)));

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      mk_sh_reg <= '0;
    end else if (bit_en) begin
      mk_sh_reg <= {mk_sh_reg[22:0], rx_data_in};
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in | clr_mode) begin
      sync_reg <= SY_SEARCH;
    end else if (wr_resync) begin
      sync_reg <= SY_SEARCH;
    end else if (det) begin
      sync_reg <= SY_LOCK;
    end
  end

  // Frame counter
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      bit_cnt_reg     <= '0;
      odd_reg         <= 1'b0;
      frame_start_out <= 1'b0;
    end else begin
      frame_start_out <= frame_end;
      if (reref) begin
        bit_cnt_reg <= mark_end;
      end else if (frame_end) begin
        bit_cnt_reg <= '0;
        odd_reg     <= ~odd_reg;
      end else if (bit_en) begin
        bit_cnt_reg <= bit_cnt_reg + FW'(1);
      end
    end
  end

  // Fade detection
  logic [7:0] out_cnt_reg, in_cnt_reg;
  logic jit_ev, odd_bad, even_bad, even_good;
  logic signed [PW-1:0] abs_err;
  assign abs_err = (err < 0) ? -err : err;
  assign jit_ev  = edge_s & receiver_on_in & (abs_err > lim);
  assign odd_bad   = out_cnt_reg > {4'h0, jit_reg[3:0]};
  assign even_bad  = in_cnt_reg < 8'(MIN_VALID);
  assign even_good = in_cnt_reg > 8'(MIN_VALID);

  always_ff @(posedge ref_clk_in) begin
    if (rst_in | frame_end) begin
      out_cnt_reg <= '0;
      in_cnt_reg  <= '0;
    end else if (edge_s & receiver_on_in) begin
      if (jit_ev & odd_reg & ~&out_cnt_reg) out_cnt_reg <= out_cnt_reg + 8'h01;
      if (~jit_ev & ~&in_cnt_reg) in_cnt_reg <= in_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      fade_reg       <= 1'b0;
      jitter_irq_out <= 1'b0;
    end else begin
      jitter_irq_out <= 1'b0;
      if (frame_end & odd_reg) begin
        jitter_irq_out <= odd_bad;
        if (odd_bad) fade_reg <= 1'b1;
        else if (even_good) fade_reg <= 1'b0;
      end else if (frame_end & ~odd_reg) begin
        jitter_irq_out <= even_bad;
        if (even_bad) fade_reg <= 1'b1;
        else if (even_good) fade_reg <= 1'b0;
      end
    end
  end

  // Long-term frequency averaging
  logic signed [15:0] lt_sum_reg, lt_sum_next;
  logic [5:0] lt_cnt_reg;
  logic lt_on;
  assign lt_on = portable & lf_reg[LF_LONG_TERM_CORRECT_ENABLE];
  // Fade frames add nothing yet still count toward the 32
  assign lt_sum_next = lt_sum_reg + (fade_reg ? 16'sh0000 : 16'(corr));

  always_ff @(posedge ref_clk_in) begin
    if (rst_in | ~lt_on | wr_resync | ~locked) begin
      lt_reg     <= LT_IDLE;
      lt_sum_reg <= '0;
      lt_cnt_reg <= '0;
      lt_off_reg <= '0;
    end else begin
      case (lt_reg)
        LT_IDLE: begin
          lt_reg <= LT_MEAS;
        end
        LT_MEAS: begin
          lt_sum_reg <= lt_sum_next;
          if (frame_end) lt_cnt_reg <= lt_cnt_reg + 6'h01;
          if (frame_end & (lt_cnt_reg == 6'(LT_FRAMES - 1))) begin
            lt_reg     <= LT_APPLY;
            lt_off_reg <= PW'(lt_sum_next >>> LT_SHIFT);
          end
        end
        default: lt_reg <= LT_APPLY;
      endcase
    end
  end

  // Code word transmitter
  logic [63:0] tx_sh_reg;
  logic [6:0]  tx_cnt_reg;
  logic [2:0]  words_reg;
  logic        idle_reg, tx_stop_reg;
  logic [62:0] cw_body;
  assign cw_body = {cw_data_in, cw_check_in};
  assign tx_allowed_out = ~tx_stop_reg;
  assign cw_ready_out   = (tx_reg == TX_IDLE) & bit_en & ~tx_stop_reg;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in | wr_resync) begin
      tx_stop_reg <= 1'b1;
    end else if (locked | (fixed_u & ~clr_mode & (mux_reg[1:0] != MUX_REVERSE))) begin
      tx_stop_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in | tx_stop_reg) begin
      tx_reg     <= TX_IDLE;
      tx_sh_reg  <= '0;
      tx_cnt_reg <= '0;
      words_reg  <= '0;
      idle_reg   <= 1'b0;
      tx_bit_out <= 1'b0;
    end else if (bit_en) begin
      case (tx_reg)
        TX_IDLE: begin
          idle_reg   <= ~idle_reg;
          tx_bit_out <= idle_reg;
          if (cw_valid_in) begin
            tx_sh_reg <= {cw_body, ^cw_body};
            if (cw_first_in | (words_reg == 3'(MAX_WORDS))) begin
              tx_reg     <= TX_SYNC;
              tx_cnt_reg <= 7'(SYNC_BITS - 1);
              words_reg  <= 3'h1;
            end else begin
              tx_reg     <= TX_WORD;
              tx_cnt_reg <= 7'(CW_BITS - 1);
              words_reg  <= words_reg + 3'h1;
            end
          end
        end
        TX_SYNC: begin
          tx_bit_out <= PKT_SYNC[tx_cnt_reg[3:0]];
          tx_cnt_reg <= tx_cnt_reg - 7'h01;
          if (tx_cnt_reg == '0) begin
            tx_reg     <= TX_WORD;
            tx_cnt_reg <= 7'(CW_BITS - 1);
          end
        end
        default: begin
          tx_bit_out <= tx_sh_reg[63];
          tx_sh_reg  <= {tx_sh_reg[62:0], 1'b0};
          tx_cnt_reg <= tx_cnt_reg - 7'h01;
          if (tx_cnt_reg == '0) tx_reg <= TX_IDLE;
        end
      endcase
    end
  end

  // Register file
  logic wr_cause;
  assign wr_cause = wr_in & (addr_in == ADDR_IRQ_CAUSE);
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      rt_reg   <= RST_ZERO;
      lf_reg   <= RST_ZERO;
      jit_reg  <= RST_JITTER;
      mt_reg   <= RST_ZERO;
      dly_reg  <= RST_ZERO;
      role_reg <= RST_ZERO;
      mux_reg  <= {6'h00, MUX_CLEAR};
      mask_reg <= RST_MASK;
    end else if (wr_in) begin
      if (addr_in == ADDR_RX_TIMING) rt_reg <= wdata_in;
      else if (addr_in == ADDR_LOOP_FILTER) lf_reg <= wdata_in;
      else if (addr_in == ADDR_JITTER) jit_reg <= wdata_in;
      else if (addr_in == ADDR_MODEM_TMG) mt_reg <= wdata_in;
      else if (addr_in == ADDR_MODEM_DLY) dly_reg <= wdata_in;
      else if (addr_in == ADDR_ROLE & clr_mode) role_reg <= wdata_in;
      else if (addr_in == ADDR_RX_MUX) mux_reg <= wdata_in;
      else if (addr_in == ADDR_IRQ_MASK) mask_reg <= wdata_in;
    end
  end

  // Cause bits: write one to clear; a new event wins over the clear
  logic [7:0] cause_set;
  always_comb begin
    cause_set = '0;
    cause_set[MC_MARKER]   = det;
    cause_set[MC_SYNC_ERR] = miss;
  end
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      cause_reg <= '0;
    end else begin
      cause_reg <= (cause_reg & ~(wr_cause ? wdata_in : 8'h00)) | cause_set;
    end
  end
  assign marker_irq_out = |(cause_reg & mask_reg);

  logic [7:0] lf_rd, rt_rd, mt_rd;
  always_comb begin
    lf_rd = lf_reg;
    lf_rd[LF_FADE] = fade_reg;
    rt_rd = rt_reg;
    rt_rd[RT_TRACK]  = tracking;
    rt_rd[RT_SYNCED] = locked;
    mt_rd = mt_reg;
    if (indep) mt_rd[MT_OVERRIDE] = 1'b1;
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      rdata_out <= '0;
    end else if (rd_in) begin
      if (addr_in == ADDR_RX_TIMING) rdata_out <= rt_rd;
      else if (addr_in == ADDR_LOOP_FILTER) rdata_out <= lf_rd;
      else if (addr_in == ADDR_JITTER) rdata_out <= jit_reg;
      else if (addr_in == ADDR_MODEM_TMG) rdata_out <= mt_rd;
      else if (addr_in == ADDR_MODEM_DLY) rdata_out <= dly_reg;
      else if (addr_in == ADDR_ROLE) rdata_out <= role_reg;
      else if (addr_in == ADDR_RX_MUX) rdata_out <= mux_reg;
      else if (addr_in == ADDR_IRQ_CAUSE) rdata_out <= cause_reg;
      else if (addr_in == ADDR_IRQ_MASK) rdata_out <= mask_reg;
      else rdata_out <= 8'h00;
    end else begin
      rdata_out <= 8'h00;
    end
  end

  // Delay forced to zero in independent timing or with the override bit; data accepted only while receiver is on
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      modem_delay_out <= '0;
      synced_out      <= 1'b0;
      fade_out        <= 1'b0;
    end else begin
      modem_delay_out <= (indep | mt_reg[MT_OVERRIDE]) ? 8'h00 : dly_reg;
      synced_out      <= locked;
      fade_out        <= fade_reg;
    end
  end
endmodule
`default_nettype wire

/* File: tb/rbs_timing_assertions.sv */
// Concurrent checks on the receive timing block ports.
// Assumes BIT_CYC of at least 8 and one register master.
`timescale 1ns/100ps
`default_nettype none
module rbs_timing_assertions
  import rbs_pkg::*;
#(
  parameter int BIT_CYC    = 36,
  parameter int FRAME_BITS = 160
) (
  input wire logic       ref_clk_in,
  input wire logic       rst_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       wr_in,
  input wire logic       rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic       cw_ready_out,
  input wire logic       tx_bit_out,
  input wire logic       tx_allowed_out,
  input wire logic       synced_out,
  input wire logic       fade_out,
  input wire logic       jitter_irq_out,
  input wire logic       slip_out,
  input wire logic       frame_start_out,
  input wire logic [7:0] modem_delay_out
);
  logic       indep_reg;
  logic       portable_reg;
  logic [1:0] mux_reg;
  // Shadow of the role inputs, since the checker cannot see registers
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      indep_reg    <= 1'b0;
      portable_reg <= 1'b0;
      mux_reg      <= MUX_CLEAR;
    end else if (wr_in) begin
      if (addr_in == ADDR_LOOP_FILTER) indep_reg <= wdata_in[LF_INDEP];
      if (addr_in == ADDR_RX_MUX) mux_reg <= wdata_in[1:0];
      if (addr_in == ADDR_ROLE && mux_reg == MUX_CLEAR) portable_reg <= wdata_in[0];
    end
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data outside read answer cycle");
  a_unmapped_read: assert property ($past(rd_in) && $past(addr_in) > ADDR_RESYNC
    |-> rdata_out == 8'h00)
    else $error("unmapped read not zero");
  a_resync_stops: assert property (wr_in && addr_in == ADDR_RESYNC
    |=> !tx_allowed_out ##1 !synced_out)
    else $error("resync left lock or transmission");
  a_ready_allowed: assert property (cw_ready_out |-> tx_allowed_out)
    else $error("word taken while stopped");
  a_ready_pulse: assert property (cw_ready_out |=> !cw_ready_out)
    else $error("ready longer than one cycle");
  a_bit_stands: assert property ($changed(tx_bit_out) |=> $stable(tx_bit_out) [*4])
    else $error("transmit bit too short");
  a_indep_delay: assert property (indep_reg && !portable_reg && $past(indep_reg, 2)
    |-> modem_delay_out == 8'h00)
    else $error("modem delay not zero in independent timing");
  a_jitter_fade: assert property (jitter_irq_out |-> ##[0:1] fade_out)
    else $error("jitter interrupt without fade");
  a_slip_fixed: assert property (slip_out |-> !portable_reg)
    else $error("slip in portable unit");
  a_frame_pulse: assert property (frame_start_out |=> !frame_start_out)
    else $error("frame start longer than one cycle");
  c_word: cover property (cw_ready_out);
  c_lock: cover property ($rose(synced_out));
  c_jitter: cover property (jitter_irq_out);
endmodule
bind rbs_timing rbs_timing_assertions #(.BIT_CYC(BIT_CYC), .FRAME_BITS(FRAME_BITS)) u_chk (
  .ref_clk_in(ref_clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .cw_ready_out(cw_ready_out),
  .tx_bit_out(tx_bit_out), .tx_allowed_out(tx_allowed_out), .synced_out(synced_out),
  .fade_out(fade_out), .jitter_irq_out(jitter_irq_out), .slip_out(slip_out),
  .frame_start_out(frame_start_out), .modem_delay_out(modem_delay_out));
`default_nettype wire

/* File: tb/rbs_remote.sv */
// Remote radio unit: sends preamble and marker once per frame.
// Assumes the same bit and frame lengths as the block under test.
`timescale 1ns/100ps
`default_nettype none
module rbs_remote
  import rbs_pkg::*;
#(
  parameter int          BIT_CYC    = 8,
  parameter int          FRAME_BITS = 64,
  parameter logic [23:0] MARKER     = 24'h5A_3C96
) (
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  input  wire logic       on_in,
  input  wire logic [5:0] flip_in,
  output logic            rx_data_out
);
  logic [33:0] burst;
  int          cyc_reg;
  int          bit_reg;
  // Flip index past 33 leaves the burst clean
  assign burst = {10'h2AA, MARKER} ^ (34'h0_0000_0001 << flip_in);
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      cyc_reg     <= 0;
      bit_reg     <= 0;
      rx_data_out <= 1'b0;
    end else begin
      cyc_reg <= (cyc_reg == BIT_CYC - 1) ? 0 : cyc_reg + 1;
      if (cyc_reg == BIT_CYC - 1) bit_reg <= (bit_reg == FRAME_BITS - 1) ? 0 : bit_reg + 1;
      // Silence is a flat line: no edges, so even frames see a fade
      if (cyc_reg == 0) begin
        if (!on_in) rx_data_out <= 1'b0;
        else if (bit_reg < 34) rx_data_out <= burst[33 - bit_reg];
        else rx_data_out <= bit_reg[0];
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the receive timing block and a remote unit.
// Assumes shortened bit and frame lengths; drives on rising edges.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import rbs_pkg::*;
  localparam int BC = 8;
  localparam int FB = 64;
  localparam int FC = BC * FB;
  localparam logic [23:0] MK = 24'h5A_3C96;
  logic        ref_clk_in, rst_in, wr, rd, rx, ron, on, cw_first, cw_valid;
  logic [3:0]  addr;
  logic [7:0]  wdata, rdata, mdly;
  logic [5:0]  flip;
  logic [47:0] cw_data;
  logic [14:0] cw_check;
  logic        cw_ready, tx_bit, tx_ok, synced, fade, jit, mirq, slip, fstart;
  int          err_total, comparisons;
  rbs_timing #(.BIT_CYC(BC), .FRAME_BITS(FB), .MARKER(MK)) u_dut (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
    .rd_in(rd), .rdata_out(rdata), .rx_data_in(rx), .receiver_on_in(ron),
    .cw_data_in(cw_data), .cw_check_in(cw_check), .cw_first_in(cw_first),
    .cw_valid_in(cw_valid), .cw_ready_out(cw_ready), .tx_bit_out(tx_bit),
    .tx_allowed_out(tx_ok), .synced_out(synced), .fade_out(fade), .jitter_irq_out(jit),
    .marker_irq_out(mirq), .slip_out(slip), .frame_start_out(fstart), .modem_delay_out(mdly));
  rbs_remote #(.BIT_CYC(BC), .FRAME_BITS(FB), .MARKER(MK)) u_remote (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .on_in(on), .flip_in(flip), .rx_data_out(rx));
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk_in);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk_in);
    rd <= 1'b0;
    @(negedge ref_clk_in);
    d = rdata;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rreg(a, d);
    chk(d, exp);
  endtask
  task automatic wait_sync(input int n, output logic ok);
    ok = 1'b0;
    for (int i = 0; i < n && !ok; i++) begin
      @(negedge ref_clk_in);
      ok = (synced === 1'b1);
    end
  endtask
  task automatic t_regs();
    logic [7:0] exp [10];
    exp = '{RST_ZERO, RST_ZERO, RST_JITTER, RST_ZERO, RST_ZERO, RST_ZERO, 8'h03, RST_ZERO,
            RST_MASK, RST_ZERO};
    for (int i = 0; i < 10; i++) rchk(4'(i), exp[i]);
    rchk(4'hF, 8'h00);
    wreg(ADDR_LOOP_FILTER, 8'h8F);
    rchk(ADDR_LOOP_FILTER, 8'h8F);
    wreg(ADDR_LOOP_FILTER, 8'h00);
  endtask
  task automatic t_role();
    wreg(ADDR_ROLE, 8'h01);
    rchk(ADDR_ROLE, 8'h01);
    wreg(ADDR_RX_MUX, {6'h00, MUX_TWO_WAY});
    wreg(ADDR_ROLE, 8'h00);
    rchk(ADDR_ROLE, 8'h01);
    wreg(ADDR_RX_MUX, {6'h00, MUX_CLEAR});
    wreg(ADDR_ROLE, 8'h00);
    rchk(ADDR_ROLE, 8'h00);
  endtask
  task automatic t_indep();
    wreg(ADDR_MODEM_DLY, 8'h55);
    repeat (2) @(negedge ref_clk_in);
    chk(mdly, 8'h55);
    wreg(ADDR_LOOP_FILTER, 8'h10);
    repeat (2) @(negedge ref_clk_in);
    chk(mdly, 8'h00);
    rchk(ADDR_MODEM_TMG, 8'h02);
    wreg(ADDR_LOOP_FILTER, 8'h00);
  endtask
  task automatic t_lock();
    logic       ok;
    logic [7:0] d;
    int         n;
    on <= 1'b1;
    wreg(ADDR_RX_TIMING, 8'h01);
    wreg(ADDR_RX_MUX, {6'h00, MUX_TWO_WAY});
    wreg(ADDR_RESYNC, 8'h00);
    wait_sync(4 * FC, ok);
    chk({7'h00, ok}, 8'h01);
    rreg(ADDR_RX_TIMING, d);
    chk(d & 8'hC0, 8'hC0);
    rreg(ADDR_IRQ_CAUSE, d);
    chk(d & 8'h01, 8'h01);
    chk({7'h00, mirq}, 8'h01);
    n = 0;
    repeat (FC) @(negedge ref_clk_in) n += int'(slip);
    chk(n[7:0], 8'h00);
  endtask
  task automatic t_code();
    logic [95:0] cap;
    logic [79:0] exp;
    logic        hit;
    exp = {PKT_SYNC, 48'h1234_5678_9ABC, 15'h2ACE, ^{48'h1234_5678_9ABC, 15'h2ACE}};
    @(posedge ref_clk_in);
    cw_data  <= 48'h1234_5678_9ABC;
    cw_check <= 15'h2ACE;
    cw_first <= 1'b1;
    cw_valid <= 1'b1;
    hit = 1'b0;
    for (int k = 0; k < 4000 && !hit; k++) begin
      @(negedge ref_clk_in);
      hit = (cw_ready === 1'b1);
    end
    chk({7'h00, hit}, 8'h01);
    @(posedge ref_clk_in);
    cw_valid <= 1'b0;
    repeat (BC / 2) @(posedge ref_clk_in);
    for (int k = 0; k < 96; k++) begin
      cap = {cap[94:0], tx_bit};
      repeat (BC) @(posedge ref_clk_in);
    end
    hit = 1'b0;
    // Word may start up to 14 bits late; idle after it must alternate
    for (int k = 0; k < 15; k++) begin
      if (cap[95-k -: 80] === exp && cap[15-k] !== cap[14-k]) hit = 1'b1;
    end
    chk({7'h00, hit}, 8'h01);
  endtask
  task automatic t_miss();
    logic [7:0] d;
    int         n;
    on <= 1'b0;
    wreg(ADDR_IRQ_CAUSE, 8'h09);
    n = 0;
    repeat (3 * FC) @(negedge ref_clk_in) n += int'(jit);
    chk({7'h00, n > 0}, 8'h01);
    rreg(ADDR_IRQ_CAUSE, d);
    chk(d & 8'h08, 8'h08);
    chk({7'h00, fade}, 8'h01);
  endtask
  task automatic t_tol();
    logic ok;
    wreg(ADDR_RESYNC, 8'h00);
    @(negedge ref_clk_in);
    chk({7'h00, tx_ok}, 8'h00);
    @(negedge ref_clk_in);
    chk({7'h00, synced}, 8'h00);
    @(posedge ref_clk_in);
    flip <= 6'h05;
    on   <= 1'b1;
    wait_sync(3 * FC, ok);
    chk({7'h00, ok}, 8'h00);
    wreg(ADDR_RX_MUX, 8'h09);
    ron <= 1'b0;
    wait_sync(2 * FC, ok);
    chk({7'h00, ok}, 8'h00);
    @(posedge ref_clk_in);
    ron <= 1'b1;
    wait_sync(4 * FC, ok);
    chk({7'h00, ok}, 8'h01);
  endtask
  initial begin
    ref_clk_in = 1'b0;
    forever #20 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    {wr, rd, on, cw_first, cw_valid, addr, wdata, cw_data, cw_check} = '0;
    err_total   = 0;
    comparisons = 0;
    ron         = 1'b1;
    flip        = 6'h3F;
    rst_in      = 1'b1;
    repeat (2) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    t_regs();
    t_role();
    t_indep();
    t_lock();
    t_code();
    t_miss();
    t_tol();
    test_done();
  end
  initial begin
    repeat (40000) @(posedge ref_clk_in);
    err_total++;
    test_done();
  end
endmodule
`default_nettype wire
